// ==== include/sam_pkg.sv ====
// Shared constants and carrier types for the serial converter control block
package sam_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 40000000;
	localparam int unsigned SYS_CLK_PERIOD_NS = 25;
	localparam int unsigned SCLK_MIN_HZ = 5000;
	localparam int unsigned SCLK_MAX_HZ = 3000000;
	localparam int unsigned CONV_MAX_NS = 5000;
	// Longest time rounds down to whole system cycles
	localparam int unsigned CONV_MAX_CYCLES = CONV_MAX_NS / SYS_CLK_PERIOD_NS;
	localparam int unsigned WATCH_W = 8;

	// ------------------------------------------------------------------
	// Frame layout, counted in serial clock periods
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_BITS = 5;
	localparam int unsigned ACQ_SCLKS = 3;
	localparam int unsigned MAG_BITS = 10;
	localparam int unsigned RESULT_W = MAG_BITS + 1;
	localparam int unsigned CNT_W = 4;
	localparam int unsigned CHANNEL_COUNT = 8;
	localparam logic [2:0] CHANNEL_MASK = 3'h7;
	localparam logic [MAG_BITS-1:0] DAC_FIRST_TRIAL = 10'h200;
	localparam logic [MAG_BITS-1:0] DAC_ZERO = 10'h000;

	// Address word fields, first bit shifted in lands in the top position
	localparam int unsigned ADDR_PD_POS = 4;
	localparam int unsigned ADDR_SE_POS = 3;
	localparam int unsigned ADDR_CH_LSB = 0;

	// Buffer between converter and serial shifter
	localparam int unsigned BUF_DEPTH = 2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic pd_cmd;
		logic single_ended;
		logic [2:0] channel;
	} sam_addr_t;

	typedef struct packed {
		logic sign;
		logic [MAG_BITS-1:0] magnitude;
	} sam_result_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACQ = 3'h2,
		ST_CONV = 3'h3,
		ST_PUSH = 3'h4,
		ST_HOLD = 3'h5
	} sam_state_t;

endpackage : sam_pkg

// ==== rtl/sam_converter_ctrl.sv ====
// Serial control, successive approximation sequencer and result buffer
// Notes on behaviour
// - Rising serial clock edges in the address phase sample the address input into the address register.
// - Falling serial clock edges after the result is loaded put the next result bit on the serial output.
// - Shifting and output work only while chip select is low.
// - Acquisition and conversion length are counted in serial clock periods.
// - Serial output is driven only with chip select low and conversion done.
// - Result leaves lowest bit first, sign bit last, one per falling edge.
// - Result holds a sign bit plus ten magnitude bits.
// - Loaded address picks the analog channel fed to the converter.
// - Address selects single-ended or differential use, channel count up to eight.
// - Single-ended use converts the channel against the common input.
// - Power-down pin high powers the converter down; low powers it up unless an address command holds it down.
// - Power-down comes from the pin or from an address command.
// - Status output is released whenever chip select is high.
// - With chip select low status is high during conversion, low otherwise.
// - Conversion takes eleven serial periods, within the maximum conversion time only at serial rates above about 2.2 MHz.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-entry result buffer
// ----------------------------------------------------------------------
module sam_result_buf #(
	parameter int unsigned WIDTH = 11,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0] count_q;
	logic push;
	logic pop;

	// Honest full and empty from the occupancy count
	assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else if (flush)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
endmodule : sam_result_buf

// ----------------------------------------------------------------------
// Top: serial exchange and conversion sequencing
// ----------------------------------------------------------------------
module sam_converter_ctrl (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial pins from the controller
	input wire logic serial_clk,
	input wire logic chip_select_n,
	input wire logic serial_address_in,
	input wire logic powerdown_pin,
	// Serial output pin, three-state
	output logic serial_data_out,
	output logic serial_data_oe,
	// Conversion status pin, three-state
	output logic conversion_status_out,
	output logic conversion_status_oe,
	// Analog front end control
	input wire logic comparator_in,
	output logic [2:0] mux_channel,
	output logic mux_single_ended,
	output logic sample_hold,
	output logic polarity_swap,
	output logic [9:0] dac_code,
	output logic converter_powerdown,
	output logic conversion_late
);
	// ------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_n;
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic sclk_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_n_s;
	logic din_s;
	logic pd_pin_s;
	logic comp_s;

	// Reset enters asynchronously, releases through two flops
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Two flops on every pin; chip select idles high so it resets high
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pin_meta_q <= 5'h02;
			pin_sync_q <= 5'h02;
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= {comparator_in, powerdown_pin, serial_address_in,
				chip_select_n, serial_clk};
			pin_sync_q <= pin_meta_q;
			sclk_prev_q <= pin_sync_q[0];
		end
	end

	assign cs_n_s = pin_sync_q[1];
	assign din_s = pin_sync_q[2];
	assign pd_pin_s = pin_sync_q[3];
	assign comp_s = pin_sync_q[4];
	// Edges only count with chip select low
	assign sclk_rise = pin_sync_q[0] & ~sclk_prev_q & ~cs_n_s;
	assign sclk_fall = ~pin_sync_q[0] & sclk_prev_q & ~cs_n_s;

	// ------------------------------------------------------------------
	// Exchange sequencer
	// ------------------------------------------------------------------
	sam_pkg::sam_state_t state_q;
	logic [sam_pkg::CNT_W-1:0] cnt_q;
	logic [sam_pkg::ADDR_BITS-1:0] addr_sr_q;
	logic sw_pd_q;
	logic sign_q;
	logic [sam_pkg::MAG_BITS-1:0] dac_q;
	logic [sam_pkg::CNT_W-1:0] bit_idx;
	logic buf_in_ready;
	logic addr_last;
	logic pd_active;

	// Sign step is count 0, magnitude bits follow from the top down
	assign bit_idx = sam_pkg::CNT_W'(sam_pkg::MAG_BITS) - cnt_q;
	assign addr_last = (cnt_q == sam_pkg::CNT_W'(sam_pkg::ADDR_BITS - 1));
	assign pd_active = pd_pin_s | sw_pd_q;

	// State and step counter; a raised chip select abandons any frame
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_q <= sam_pkg::ST_IDLE;
			cnt_q <= '0;
		end
		else if (cs_n_s)
		begin
			state_q <= sam_pkg::ST_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				sam_pkg::ST_IDLE:
				begin
					state_q <= sam_pkg::ST_ADDR;
					cnt_q <= '0;
				end
				sam_pkg::ST_ADDR:
				begin
					if (sclk_rise)
					begin
						if (addr_last)
						begin
							// Powered down: address is taken, nothing converts
							state_q <= (pd_pin_s | addr_sr_q[sam_pkg::ADDR_PD_POS - 1]) ?
								sam_pkg::ST_HOLD : sam_pkg::ST_ACQ;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
				end
				sam_pkg::ST_ACQ:
				begin
					if (sclk_rise)
					begin
						// Acquisition window in serial periods
						if (cnt_q == sam_pkg::CNT_W'(sam_pkg::ACQ_SCLKS - 1))
						begin
							state_q <= sam_pkg::ST_CONV;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
				end
				sam_pkg::ST_CONV:
				begin
					if (sclk_rise)
					begin
						// One decision per serial period
						if (cnt_q == sam_pkg::CNT_W'(sam_pkg::MAG_BITS))
							state_q <= sam_pkg::ST_PUSH;
						else
							cnt_q <= cnt_q + 1'b1;
					end
				end
				sam_pkg::ST_PUSH:
				begin
					// Waits here if the buffer is full
					if (buf_in_ready)
						state_q <= sam_pkg::ST_HOLD;
				end
				sam_pkg::ST_HOLD:
				begin
					state_q <= sam_pkg::ST_HOLD;
				end
				default:
				begin
					state_q <= sam_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Address shift register, sampled on rising serial edges
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			addr_sr_q <= '0;
		else if (sclk_rise && state_q == sam_pkg::ST_ADDR)
			addr_sr_q <= {addr_sr_q[sam_pkg::ADDR_BITS-2:0], din_s};
	end

	// Channel and mode latched from the complete address word
	sam_pkg::sam_addr_t mux_q;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			mux_q <= '0;
			sw_pd_q <= 1'b0;
		end
		else if (sclk_rise && state_q == sam_pkg::ST_ADDR && addr_last)
		begin
			// Software power-down stays until an address clears it
			sw_pd_q <= addr_sr_q[sam_pkg::ADDR_PD_POS - 1];
			mux_q.pd_cmd <= addr_sr_q[sam_pkg::ADDR_PD_POS - 1];
			mux_q.single_ended <= addr_sr_q[sam_pkg::ADDR_SE_POS - 1];
			mux_q.channel <= {addr_sr_q[1:0], din_s} & sam_pkg::CHANNEL_MASK;
		end
	end

	// Successive approximation: sign first, then magnitude MSB down
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			sign_q <= 1'b0;
			dac_q <= sam_pkg::DAC_ZERO;
		end
		else if (state_q == sam_pkg::ST_ACQ)
		begin
			sign_q <= 1'b0;
			dac_q <= sam_pkg::DAC_ZERO;
		end
		else if (sclk_rise && state_q == sam_pkg::ST_CONV)
		begin
			if (cnt_q == '0)
			begin
				// Negative side higher gives a set sign, front end swaps polarity
				sign_q <= comp_s;
				dac_q <= sam_pkg::DAC_FIRST_TRIAL;
			end
			else
			begin
				if (!comp_s)
					dac_q[bit_idx] <= 1'b0;
				if (bit_idx != '0)
					dac_q[bit_idx - 1'b1] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Conversion time watch
	// ------------------------------------------------------------------
	logic [sam_pkg::WATCH_W-1:0] watch_q;
	logic late_q;

	// Flags a conversion slower than the maximum, i.e. serial clock too slow
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			watch_q <= '0;
			late_q <= 1'b0;
		end
		else if (state_q != sam_pkg::ST_CONV)
			watch_q <= '0;
		else if (watch_q == sam_pkg::WATCH_W'(sam_pkg::CONV_MAX_CYCLES))
			late_q <= 1'b1;
		else
			watch_q <= watch_q + 1'b1;
	end

	// ------------------------------------------------------------------
	// Result buffer and serial shifter
	// ------------------------------------------------------------------
	sam_pkg::sam_result_t buf_in;
	sam_pkg::sam_result_t buf_out;
	logic buf_out_valid;
	logic buf_pop;
	logic [sam_pkg::RESULT_W-1:0] shift_q;
	logic [sam_pkg::CNT_W-1:0] shift_cnt_q;
	logic loaded_q;
	logic shifting_q;

	assign buf_in.sign = sign_q;
	assign buf_in.magnitude = dac_q;
	// Shifter drains one word per frame; a busy shifter stalls the buffer
	assign buf_pop = ~loaded_q & ~cs_n_s;

	sam_result_buf #(
		.WIDTH(sam_pkg::RESULT_W),
		.DEPTH(sam_pkg::BUF_DEPTH)
	) u_result_buf (
		.clk(sys_clk),
		.rst_n(rst_sync_n),
		.flush(cs_n_s),
		.in_valid(state_q == sam_pkg::ST_PUSH),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out)
	);

	// Word order: lowest magnitude bit first, sign last
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			shift_q <= '0;
			shift_cnt_q <= '0;
			loaded_q <= 1'b0;
			shifting_q <= 1'b0;
		end
		else if (cs_n_s)
		begin
			loaded_q <= 1'b0;
			shifting_q <= 1'b0;
			shift_cnt_q <= '0;
		end
		else if (buf_out_valid && buf_pop)
		begin
			shift_q <= buf_out;
			loaded_q <= 1'b1;
			shifting_q <= 1'b1;
			shift_cnt_q <= '0;
		end
		else if (sclk_fall && shifting_q)
		begin
			shift_q <= {1'b0, shift_q[sam_pkg::RESULT_W-1:1]};
			if (shift_cnt_q == sam_pkg::CNT_W'(sam_pkg::RESULT_W - 1))
				shifting_q <= 1'b0;
			else
				shift_cnt_q <= shift_cnt_q + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers, all registered
	// ------------------------------------------------------------------
	logic dout_q;
	logic dout_oe_q;
	logic stat_q;
	logic stat_oe_q;

	// Output released until a finished result is loaded in this frame
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			dout_q <= 1'b0;
			dout_oe_q <= 1'b0;
		end
		else
		begin
			dout_oe_q <= ~cs_n_s & loaded_q;
			dout_q <= ~cs_n_s & loaded_q & shift_q[0];
		end
	end

	// Status driven only with chip select low, high while converting
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			stat_q <= 1'b0;
			stat_oe_q <= 1'b0;
		end
		else
		begin
			stat_oe_q <= ~cs_n_s;
			stat_q <= ~cs_n_s & (state_q == sam_pkg::ST_CONV);
		end
	end

	// Front end controls; sample while acquiring, hold otherwise
	logic hold_q;
	logic swap_q;
	logic pd_q;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			hold_q <= 1'b1;
			swap_q <= 1'b0;
			pd_q <= 1'b1;
		end
		else
		begin
			hold_q <= (state_q != sam_pkg::ST_ACQ);
			swap_q <= sign_q;
			pd_q <= pd_active;
		end
	end

	assign serial_data_out = dout_q;
	assign serial_data_oe = dout_oe_q;
	assign conversion_status_out = stat_q;
	assign conversion_status_oe = stat_oe_q;
	assign mux_channel = mux_q.channel;
	assign mux_single_ended = mux_q.single_ended;
	assign sample_hold = hold_q;
	assign polarity_swap = swap_q;
	assign dac_code = dac_q;
	assign converter_powerdown = pd_q;
	assign conversion_late = late_q;

endmodule : sam_converter_ctrl

`default_nettype wire

// ==== sim/sam_ctrl_chk.sv ====
// Pin-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sam_ctrl_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial pins
	input wire logic serial_clk,
	input wire logic chip_select_n,
	input wire logic powerdown_pin,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic conversion_status_out,
	input wire logic conversion_status_oe,
	// Front end
	input wire logic [2:0] mux_channel,
	input wire logic mux_single_ended,
	input wire logic sample_hold,
	input wire logic converter_powerdown
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic sclk_q;
	logic [7:0] fall_age_q;
	logic [8:0] conv_len_q;

	// Cycles since a serial fall; the pin is synchronised, so bits lag it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q <= 1'b0;
			fall_age_q <= 8'hFF;
		end
		else
		begin
			sclk_q <= serial_clk;
			if (sclk_q && !serial_clk)
				fall_age_q <= 8'h00;
			else if (fall_age_q != 8'hFF)
				fall_age_q <= fall_age_q + 8'h01;
		end
	end

	// Length of the running conversion
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			conv_len_q <= 9'h000;
		else if (conversion_status_out)
			conv_len_q <= conv_len_q + 9'h001;
		else
			conv_len_q <= 9'h000;
	end

	// ----
	// Assertions
	// ----
	a_do_off_cs: assert property (chip_select_n [*6] |-> !serial_data_oe)
		else $error("data driven while deselected");
	a_stat_off_cs: assert property (chip_select_n [*6] |-> !conversion_status_oe)
		else $error("status driven while deselected");
	a_stat_on_cs: assert property (!chip_select_n [*8] |-> conversion_status_oe)
		else $error("status released while selected");
	a_oe_after_done: assert property ($rose(serial_data_oe) |-> !conversion_status_out)
		else $error("data driven before conversion end");
	a_bit_on_fall: assert property (serial_data_oe && $past(serial_data_oe)
		&& $changed(serial_data_out) |-> fall_age_q <= 8'h06)
		else $error("data bit moved without a fall");
	a_conv_bounded: assert property (conv_len_q <= 9'(sam_pkg::CONV_MAX_CYCLES))
		else $error("conversion too long");
	a_hold_in_conv: assert property (conversion_status_out && $past(conversion_status_out)
		|-> sample_hold)
		else $error("sampling during conversion");
	a_mux_steady: assert property (conversion_status_out && $past(conversion_status_out)
		|-> $stable(mux_channel) && $stable(mux_single_ended))
		else $error("channel moved during conversion");
	a_pd_pin: assert property (powerdown_pin [*8] |-> converter_powerdown)
		else $error("pin power-down ignored");
	a_pd_no_conv: assert property (converter_powerdown |-> !$rose(conversion_status_out))
		else $error("conversion while powered down");

	// Main scenarios reached
	c_conv: cover property ($fell(conversion_status_out));
	c_read: cover property ($rose(serial_data_oe));
	c_abort: cover property (conversion_status_out && chip_select_n);
endmodule : sam_ctrl_chk

bind sam_converter_ctrl sam_ctrl_chk u_sam_ctrl_chk (
	.sys_clk,
	.rst_n,
	.serial_clk,
	.chip_select_n,
	.powerdown_pin,
	.serial_data_out,
	.serial_data_oe,
	.conversion_status_out,
	.conversion_status_oe,
	.mux_channel,
	.mux_single_ended,
	.sample_hold,
	.converter_powerdown
);
`default_nettype wire

// ==== sim/sam_host_model.sv ====
// Host controller model driving the serial pins and the comparator
`timescale 1ns/10ps
`default_nettype none
module sam_host_model (
	// Clock
	input wire logic sys_clk,
	// Driven pins
	output logic serial_clk,
	output logic chip_select_n,
	output logic serial_address_in,
	output logic comparator_in,
	// Observed pins
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic conversion_status_out,
	input wire logic conversion_status_oe
);
	// Samples taken just before each serial fall
	logic dq[1:30];
	logic doe[1:30];
	logic st[1:30];
	logic stoe[1:30];

	// Idle pins
	initial
	begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_address_in = 1'b0;
		comparator_in = 1'b0;
	end

	// One frame of n periods; the clock stays parked low outside it
	task automatic frame(input logic [4:0] a, input logic [10:0] r, input int n,
		input logic hi);
		@(negedge sys_clk);
		chip_select_n = hi;
		repeat (6) @(negedge sys_clk);
		for (int p = 1; p <= n; p++)
		begin
			// Address line toggles when unused so no stale level is read
			serial_address_in = (p <= 5) ? a[5 - p] : ~serial_address_in;
			comparator_in = (p >= 9 && p <= 19) ? r[19 - p] : 1'b0;
			repeat (7) @(negedge sys_clk);
			serial_clk = 1'b1;
			// Longer high phase after the last decision leaves room for the load
			repeat ((p == 19) ? 16 : 7) @(negedge sys_clk);
			dq[p] = serial_data_out;
			doe[p] = serial_data_oe;
			st[p] = conversion_status_out;
			stoe[p] = conversion_status_oe;
			serial_clk = 1'b0;
		end
		repeat (7) @(negedge sys_clk);
		chip_select_n = 1'b1;
		serial_address_in = ~serial_address_in;
		repeat (6) @(negedge sys_clk);
	endtask : frame
endmodule : sam_host_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the serial converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk;
	logic rst_n;
	logic serial_clk;
	logic chip_select_n;
	logic serial_address_in;
	logic powerdown_pin;
	logic comparator_in;
	logic serial_data_out;
	logic serial_data_oe;
	logic conversion_status_out;
	logic conversion_status_oe;
	logic [2:0] mux_channel;
	logic mux_single_ended;
	logic sample_hold;
	logic polarity_swap;
	logic [9:0] dac_code;
	logic converter_powerdown;
	logic conversion_late;
	logic [5:0] mid;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	sam_converter_ctrl u_sam_converter_ctrl (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.serial_address_in(serial_address_in),
		.powerdown_pin(powerdown_pin),
		.serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe),
		.conversion_status_out(conversion_status_out),
		.conversion_status_oe(conversion_status_oe),
		.comparator_in(comparator_in),
		.mux_channel(mux_channel),
		.mux_single_ended(mux_single_ended),
		.sample_hold(sample_hold),
		.polarity_swap(polarity_swap),
		.dac_code(dac_code),
		.converter_powerdown(converter_powerdown),
		.conversion_late(conversion_late)
	);

	sam_host_model u_sam_host_model (
		.sys_clk(sys_clk),
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.serial_address_in(serial_address_in),
		.comparator_in(comparator_in),
		.serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe),
		.conversion_status_out(conversion_status_out),
		.conversion_status_oe(conversion_status_oe)
	);

	// 40 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Hang guard, about twice the expected run
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 16000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp)
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			failures++;
	endtask : check

	task automatic test_done();
		$display("Compares %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// Frame with a mid-conversion snapshot of the front-end controls
	task automatic run(input logic [4:0] a, input logic [10:0] r, input int n);
		fork
			u_sam_host_model.frame(a, r, n, 1'b0);
			begin
				repeat (180) @(negedge sys_clk);
				mid = {sample_hold, converter_powerdown, mux_single_ended, mux_channel};
			end
		join
	endtask : run

	// Full conversion and read-out, judged bit by bit
	task automatic good(input logic [4:0] a, input logic [10:0] r);
		logic [10:0] got;
		logic [10:0] on;
		run(a, r, 30);
		for (int k = 0; k < 11; k++)
		begin
			got[k] = u_sam_host_model.dq[19 + k];
			on[k] = u_sam_host_model.doe[19 + k];
		end
		check(got, r);
		check(on, 11'h7FF);
		check(11'(mid), 11'({2'b10, a[3:0]}));
		check(11'(u_sam_host_model.dq[30]), 11'h000);
		// Front end keeps the last decisions after the frame: sign and trial code
		check({polarity_swap, dac_code}, r);
		check(11'({u_sam_host_model.st[6], u_sam_host_model.st[12],
			u_sam_host_model.st[18], u_sam_host_model.st[19]}), 11'h006);
		check(11'({serial_data_oe, conversion_status_oe, conversion_late}), 11'h000);
	endtask : good

	// Every channel, odd channels single-ended and even channels differential
	task automatic t_modes();
		for (int c = 0; c < 8; c++)
			good({1'b0, 1'(c), 3'(c)}, {3'(c), 8'h5A});
	endtask : t_modes

	// Power-down by command, then by pin; no conversion or output either way
	task automatic t_powerdown();
		run(5'h18, 11'h7FF, 30);
		check(11'({mid[4], u_sam_host_model.st[12], u_sam_host_model.doe[25]}), 11'h004);
		good(5'h08, 11'h155);
		powerdown_pin = 1'b1;
		run(5'h08, 11'h7FF, 30);
		check(11'({mid[4], u_sam_host_model.st[12], u_sam_host_model.doe[25]}), 11'h004);
		powerdown_pin = 1'b0;
		good(5'h0F, 11'h000);
	endtask : t_powerdown

	// Chip select raised mid-conversion, then a clean frame
	task automatic t_abort();
		run(5'h0A, 11'h3C3, 13);
		check(11'({u_sam_host_model.st[12], serial_data_oe, conversion_status_oe}), 11'h004);
		good(5'h0B, 11'h7FF);
	endtask : t_abort

	// Clocking with chip select high must stay invisible
	task automatic t_deselected();
		logic seen;
		seen = 1'b0;
		u_sam_host_model.frame(5'h08, 11'h7FF, 30, 1'b1);
		for (int p = 1; p <= 30; p++)
			seen = seen | u_sam_host_model.doe[p] | u_sam_host_model.stoe[p];
		check(11'(seen), 11'h000);
		good(5'h0E, 11'h400);
	endtask : t_deselected

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		powerdown_pin = 1'b0;
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge sys_clk);
		check(11'({serial_data_oe, conversion_status_oe, sample_hold}), 11'h001);
		t_modes();
		t_powerdown();
		t_abort();
		t_deselected();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
